// ---- core/oscb_bank.sv ----
// Purpose: Shadow registers, lock key and programming commands
// Assumes: Write/read strobes from the serial register port, same clock
// Notes:   sys_rst_i stands for power-on: shadows reload from the array
//
// Functional notes
// - Every location holds exactly eight bits
// - Programmed bits only go zero to one
// - Shadows load from array; no automatic writeback
// - Locked at power-on except few addresses
// - Key 0xab at 0x10 unlocks
// - Unlocked writes kept until power off
// - Other value at 0x10 relocks
// - Only command writes program the array
// - Shadow range is 0x00 through 0x0d
// - Zero offset low 0x02, high 0x03
// - Bit 7 selects commutation or pulse output
// - Bits 6:5 set pulse period
// - Bits 4:3 set index width
// - Pole pairs equal code plus one
// - Counts are 32 shifted by code
// - Bits 3:0 set hysteresis, zero off
// - Bit 7 chooses counting sense
// - Bit 6 low-delay, host sets field 0101
// - Bits 5:4 set absolute position width
// - Position reported relative to zero offset
// - 0xa2 at 0x12 programs zero bytes
`timescale 1ns/1ps
module oscb_bank (
  input  wire logic                        mclk_i,
  input  wire logic                        sys_rst_i,
  input  wire logic                        wr_i,
  input  wire logic                        rd_i,
  input  wire logic [oscb_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [oscb_pkg::DATA_W-1:0] wdata_i,
  input  wire logic [15:0]                 raw_angle_i,
  output logic      [oscb_pkg::DATA_W-1:0] rdata_o,
  output logic                             rvalid_o,
  output logic                             ready_o,
  output logic                             unlocked_o,
  output logic                             prog_busy_o,
  output logic [15:0]                      position_o,
  output oscb_pkg::oscb_cfg_t              cfg_o
);

  ////////////////////////////////////////////////////////////////////////
  // State
  typedef struct packed {
    oscb_pkg::oscb_state_t        state;
    logic [oscb_pkg::ADDR_W-1:0]  idx;
    logic [oscb_pkg::ADDR_W-1:0]  last;
    logic                         unlocked;
    logic [oscb_pkg::DATA_W-1:0]  rdata;
    logic                         rvalid;
    logic [15:0]                  position;
    logic [13:0][7:0]             shadow;
    logic [7:0]                   cal_key;
  } oscb_regs_t;

  oscb_regs_t             st_r;
  oscb_regs_t             st_nxt;
  oscb_pkg::oscb_nv_req_t nv_req;
  logic [7:0]             nv_rdata;
  logic [4:0]             nv_raddr;
  logic                   open_addr;
  logic                   in_shadow;
  logic                   do_write;

  oscb_nvmem u_nvmem (
    .mclk_i     (mclk_i),
    .req_i      (nv_req),
    .raddr_i    (nv_raddr),
    .rdata_o    (nv_rdata)
  );

  ////////////////////////////////////////////////////////////////////////
  // Address classes
  // always-open addresses
  assign open_addr = (addr_i <= oscb_pkg::ADDR_ZERO_HI) ||
                     (addr_i >= oscb_pkg::ADDR_KEY &&
                      addr_i <= oscb_pkg::ADDR_CMD_ZERO) ||
                     (addr_i == oscb_pkg::ADDR_CMD_CAL);
  assign in_shadow = (addr_i <= oscb_pkg::ADDR_SHADOW_HI);
  assign do_write  = wr_i && (st_r.unlocked || open_addr) &&
                     (st_r.state == oscb_pkg::OSCB_IDLE);
  assign ready_o   = (st_r.state == oscb_pkg::OSCB_IDLE);

  ////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    st_nxt       = st_r;
    st_nxt.rvalid = 1'b0;
    nv_req       = '0;
    nv_raddr     = st_r.idx;
    case (st_r.state)
      oscb_pkg::OSCB_LOAD: begin
        if (st_r.idx != 5'h00 || st_r.last != 5'h00) begin
          st_nxt.shadow[st_r.last[3:0]] = nv_rdata;
        end
        st_nxt.last = st_r.idx;
        if (st_r.idx == 5'(oscb_pkg::SHADOW_LAST + 1)) begin
          st_nxt.state = oscb_pkg::OSCB_IDLE;
        end else begin
          st_nxt.idx = 5'(st_r.idx + 5'h01);
        end
      end
      oscb_pkg::OSCB_IDLE: begin
        if (rd_i) begin
          st_nxt.rvalid = 1'b1;
          st_nxt.rdata  = in_shadow ? st_r.shadow[addr_i[3:0]] :
                          (addr_i == oscb_pkg::ADDR_KEY) ?
                          {7'h00, st_r.unlocked} : 8'h00;
        end
        if (do_write) begin
          if (in_shadow) begin
            st_nxt.shadow[addr_i[3:0]] = wdata_i;
          end
          if (addr_i == oscb_pkg::ADDR_KEY) begin
            st_nxt.unlocked = (wdata_i == oscb_pkg::KEY_UNLOCK);
          end
          if (addr_i == oscb_pkg::ADDR_CMD_ZERO &&
              wdata_i == oscb_pkg::CMD_PROG_ZERO) begin
            st_nxt.idx   = oscb_pkg::ADDR_ZERO_LO;
            st_nxt.last  = oscb_pkg::ADDR_ZERO_HI;
            st_nxt.state = oscb_pkg::OSCB_PROG;
          end
          if (addr_i == oscb_pkg::ADDR_CMD_HI &&
              wdata_i == oscb_pkg::CMD_PROG_VOLT) begin
            st_nxt.idx   = oscb_pkg::ADDR_SUPPLY;
            st_nxt.last  = oscb_pkg::ADDR_SUPPLY;
            st_nxt.state = oscb_pkg::OSCB_PROG;
          end
          if (addr_i == oscb_pkg::ADDR_CMD_LO && st_r.unlocked) begin
            st_nxt.idx   = oscb_pkg::ADDR_USER0;
            st_nxt.last  = oscb_pkg::ADDR_SHADOW_HI;
            st_nxt.state = oscb_pkg::OSCB_PROG;
          end
          if (addr_i == oscb_pkg::ADDR_CMD_CAL) begin
            st_nxt.cal_key = wdata_i;
            if (wdata_i == oscb_pkg::CMD_PROG_CAL) begin
              st_nxt.state = oscb_pkg::OSCB_DONE;
            end
          end
        end
      end
      oscb_pkg::OSCB_PROG: begin
        nv_req.we    = 1'b1;
        nv_req.addr  = st_r.idx;
        nv_req.wdata = st_r.shadow[st_r.idx[3:0]];
        if (st_r.idx == st_r.last) begin
          st_nxt.state = oscb_pkg::OSCB_IDLE;
        end else begin
          st_nxt.idx = 5'(st_r.idx + 5'h01);
        end
      end
      // Calibration trim lives above the shadow range
      oscb_pkg::OSCB_DONE: begin
        nv_req.we    = 1'b1;
        nv_req.addr  = oscb_pkg::ADDR_CMD_CAL;
        nv_req.wdata = st_r.cal_key;
        st_nxt.state = oscb_pkg::OSCB_IDLE;
      end
      default: begin
        st_nxt.state = oscb_pkg::OSCB_IDLE;
      end
    endcase
    st_nxt.position = 16'(raw_angle_i -
                      {st_r.shadow[3], st_r.shadow[2]});
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      st_r       <= '0;
      st_r.state <= oscb_pkg::OSCB_LOAD;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Field decode
  always_comb begin
    cfg_o.zero_offset = {st_r.shadow[3], st_r.shadow[2]};
    cfg_o.commutation_or_pulse_select = st_r.shadow[4][oscb_pkg::OUT_SEL_BIT];
    cfg_o.pwm_period_code =
      st_r.shadow[4][oscb_pkg::PWM_PER_HI:oscb_pkg::PWM_PER_LO];
    cfg_o.index_width_code =
      st_r.shadow[4][oscb_pkg::IDX_W_HI:oscb_pkg::IDX_W_LO];
    cfg_o.pole_pairs = {1'b0, st_r.shadow[4][oscb_pkg::POLE_HI:0]} + 4'h1;
    cfg_o.counts_per_rev = oscb_pkg::CPR_BASE <<
      st_r.shadow[5][oscb_pkg::CPR_HI:oscb_pkg::CPR_LO];
    cfg_o.hysteresis_code = st_r.shadow[5][oscb_pkg::HYST_HI:0];
    cfg_o.count_ccw = st_r.shadow[6][oscb_pkg::DIR_BIT];
    cfg_o.low_delay = st_r.shadow[6][oscb_pkg::LOWLAT_BIT];
    cfg_o.abs_width_code = st_r.shadow[6][oscb_pkg::ABS_HI:oscb_pkg::ABS_LO];
    cfg_o.abs_bits = 5'(5'd16 - {2'b00, cfg_o.abs_width_code, 1'b0});
    cfg_o.cpr2_code = st_r.shadow[6][oscb_pkg::CPR2_HI:0];
    cfg_o.supply_high = st_r.shadow[10][oscb_pkg::SUPPLY_BIT];
  end

  assign rdata_o     = st_r.rdata;
  assign rvalid_o    = st_r.rvalid;
  assign unlocked_o  = st_r.unlocked;
  assign prog_busy_o = (st_r.state != oscb_pkg::OSCB_IDLE);
  assign position_o  = st_r.position;

endmodule // oscb_bank

// ---- core/oscb_pkg.sv ----
// Purpose: Constants and types for the angle encoder configuration store
// Assumes: Byte-wide register port, one clock
// Notes:   Every offset, field position and command value lives here
package oscb_pkg;

  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NV_DEPTH = 32;
  localparam int unsigned SHADOW_LAST = 13;

  localparam logic [4:0] ADDR_USER0     = 5'h00;
  localparam logic [4:0] ADDR_USER1     = 5'h01;
  localparam logic [4:0] ADDR_ZERO_LO   = 5'h02;
  localparam logic [4:0] ADDR_ZERO_HI   = 5'h03;
  localparam logic [4:0] ADDR_OUT_CFG   = 5'h04;
  localparam logic [4:0] ADDR_INC_CFG   = 5'h05;
  localparam logic [4:0] ADDR_RES_CFG   = 5'h06;
  localparam logic [4:0] ADDR_SUPPLY    = 5'h0a;
  localparam logic [4:0] ADDR_SHADOW_HI = 5'h0d;
  localparam logic [4:0] ADDR_KEY       = 5'h10;
  localparam logic [4:0] ADDR_CMD_LO    = 5'h11;
  localparam logic [4:0] ADDR_CMD_ZERO  = 5'h12;
  localparam logic [4:0] ADDR_CMD_HI    = 5'h14;
  localparam logic [4:0] ADDR_CMD_CAL   = 5'h1b;

  localparam logic [7:0] KEY_UNLOCK     = 8'hab;
  localparam logic [7:0] CMD_PROG_ZERO  = 8'ha2;
  localparam logic [7:0] CMD_PROG_VOLT  = 8'ha4;
  localparam logic [7:0] CMD_PROG_CAL   = 8'ha5;
  localparam logic [7:0] SHADOW_RST     = 8'h00;

  localparam int unsigned OUT_SEL_BIT   = 7;
  localparam int unsigned PWM_PER_HI    = 6;
  localparam int unsigned PWM_PER_LO    = 5;
  localparam int unsigned IDX_W_HI      = 4;
  localparam int unsigned IDX_W_LO      = 3;
  localparam int unsigned POLE_HI       = 2;
  localparam int unsigned CPR_HI        = 7;
  localparam int unsigned CPR_LO        = 4;
  localparam int unsigned HYST_HI       = 3;
  localparam int unsigned DIR_BIT       = 7;
  localparam int unsigned LOWLAT_BIT    = 6;
  localparam int unsigned ABS_HI        = 5;
  localparam int unsigned ABS_LO        = 4;
  localparam int unsigned CPR2_HI       = 3;
  localparam int unsigned SUPPLY_BIT    = 1;

  // Base count for count-resolution shift
  localparam logic [12:0] CPR_BASE      = 13'h0020;

  typedef enum logic [3:0] {
    OSCB_LOAD  = 4'b0001,
    OSCB_IDLE  = 4'b0010,
    OSCB_PROG  = 4'b0100,
    OSCB_DONE  = 4'b1000
  } oscb_state_t;

  typedef struct packed {
    logic       commutation_or_pulse_select;
    logic [1:0] pwm_period_code;
    logic [1:0] index_width_code;
    logic [3:0] pole_pairs;
    logic [12:0] counts_per_rev;
    logic [3:0] hysteresis_code;
    logic       count_ccw;
    logic       low_delay;
    logic [1:0] abs_width_code;
    logic [4:0] abs_bits;
    logic [3:0] cpr2_code;
    logic       supply_high;
    logic [15:0] zero_offset;
  } oscb_cfg_t;

  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } oscb_nv_req_t;

endpackage

// ---- core/oscb_nvmem.sv ----
// Purpose: One-time-programmable byte array model
// Assumes: Contents survive sys_rst_i, which stands for power-on
// Notes:   Programming ORs new ones in; read data is registered
`timescale 1ns/1ps
module oscb_nvmem (
  input  wire logic                       mclk_i,
  input  wire oscb_pkg::oscb_nv_req_t     req_i,
  input  wire logic [oscb_pkg::ADDR_W-1:0] raddr_i,
  output logic      [oscb_pkg::DATA_W-1:0] rdata_o
);

  // byte-wide cells
  // Blank parts start all zero; no reset may clear programmed cells
  logic [oscb_pkg::DATA_W-1:0] mem_r [oscb_pkg::NV_DEPTH] =
    '{default: 8'h00};

  ////////////////////////////////////////////////////////////////////////
  // ones only added
  always_ff @(posedge mclk_i) begin
    if (req_i.we) begin
      mem_r[req_i.addr] <= mem_r[req_i.addr] | req_i.wdata;
    end
  end

  always_ff @(posedge mclk_i) begin
    rdata_o <= mem_r[raddr_i];
  end

endmodule // oscb_nvmem

// ---- testbench/oscb_bank_props.sv ----
// Purpose: Port-level properties of the configuration store
// Assumes: Bound to oscb_bank, single clock domain
// Notes:   Watches design ports only
`timescale 1ns/1ps
module oscb_bank_props (
  input wire logic             mclk_i,
  input wire logic             sys_rst_i,
  input wire logic             wr_i,
  input wire logic             rd_i,
  input wire logic [4:0]       addr_i,
  input wire logic [7:0]       wdata_i,
  input wire logic [15:0]      raw_angle_i,
  input wire logic [7:0]       rdata_o,
  input wire logic             rvalid_o,
  input wire logic             ready_o,
  input wire logic             unlocked_o,
  input wire logic             prog_busy_o,
  input wire logic [15:0]      position_o,
  input wire oscb_pkg::oscb_cfg_t cfg_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  wire        wr_ok    = wr_i && ready_o;
  wire        key_wr   = wr_ok && addr_i == oscb_pkg::ADDR_KEY;
  wire        cfg_wr   = wr_ok && addr_i == oscb_pkg::ADDR_OUT_CFG;
  wire [3:0]  pole_exp = {1'b0, wdata_i[2:0]} + 4'h1;
  wire [15:0] zoff     = cfg_o.zero_offset;
  a_key_unlocks: assert property (
    key_wr && wdata_i == oscb_pkg::KEY_UNLOCK |=> unlocked_o)
    else $error("key write did not unlock");
  a_other_relocks: assert property (
    key_wr && wdata_i != oscb_pkg::KEY_UNLOCK |=> !unlocked_o)
    else $error("non-key write did not relock");
  a_lock_persists: assert property (!key_wr |=> $stable(unlocked_o))
    else $error("lock state changed without key write");
  a_locked_ignored: assert property (
    cfg_wr && !unlocked_o |=> $stable(cfg_o))
    else $error("locked write changed configuration");
  a_pole_decode: assert property (
    cfg_wr && unlocked_o |=> cfg_o.pole_pairs == $past(pole_exp))
    else $error("pole pair count wrong");
  a_zero_low: assert property (
    wr_ok && addr_i == oscb_pkg::ADDR_ZERO_LO |=> zoff[7:0] == $past(wdata_i))
    else $error("zero offset low byte not taken");
  a_position_rel: assert property (
    !$past(sys_rst_i) |-> position_o == $past(raw_angle_i) - $past(zoff))
    else $error("position not relative to offset");
  a_prog_busy: assert property (
    wr_ok && addr_i == oscb_pkg::ADDR_CMD_ZERO &&
    wdata_i == oscb_pkg::CMD_PROG_ZERO |=> prog_busy_o [*2] ##1 ready_o)
    else $error("zero programming sequence wrong");
  a_read_answers: assert property (rd_i && ready_o |=> rvalid_o)
    else $error("read not answered");
  c_unlock: cover property (key_wr && wdata_i == oscb_pkg::KEY_UNLOCK);
  c_locked: cover property (cfg_wr && !unlocked_o);
  c_prog: cover property (prog_busy_o);
  c_supply: cover property (wr_ok && addr_i == oscb_pkg::ADDR_CMD_HI &&
    wdata_i == oscb_pkg::CMD_PROG_VOLT);
endmodule // oscb_bank_props

// ---- testbench/oscb_host.sv ----
// Purpose: Host model driving the register port
// Assumes: Strobe taken on a rising edge with ready high
// Notes:   Idle data lines show inverted bytes
`timescale 1ns/1ps
module oscb_host (
  input  wire logic       mclk_i,
  input  wire logic       ready_i,
  input  wire logic       rvalid_i,
  input  wire logic [7:0] rdata_i,
  output logic            wr_o,
  output logic            rd_o,
  output logic [4:0]      addr_o,
  output logic [7:0]      wdata_o
);
  initial begin
    wr_o = 1'b0;
    rd_o = 1'b0;
    addr_o = 5'h1f;
    wdata_o = 8'h00;
  end
  // Hold request until the edge that takes it
  task automatic take;
    do @(posedge mclk_i); while (ready_i !== 1'b1);
    #2;
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    #2;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    take();
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    #2;
    addr_o = a;
    rd_o = 1'b1;
    take();
    rd_o = 1'b0;
    d = (rvalid_i === 1'b1) ? rdata_i : 8'hxx;
  endtask
endmodule // oscb_host

// ---- testbench/testbench.sv ----
// Purpose: Self-checking bench for the configuration store
// Assumes: Array contents survive sys_rst_i
// Notes:   All register traffic goes through the host model
`timescale 1ns/1ps
module testbench;
  logic                mclk_i = 1'b0;
  logic                sys_rst_i = 1'b1;
  logic                wr_i, rd_i, rvalid_o, ready_o, unlocked_o, prog_busy_o;
  logic [4:0]          addr_i;
  logic [7:0]          wdata_i, rdata_o, rd_v, d, zl, zh, inc;
  logic [15:0]         raw_angle_i = 16'h0000;
  logic [15:0]         position_o;
  oscb_pkg::oscb_cfg_t cfg_o;
  int                  bad_count = 0, tests_run = 0, cyc = 0;
  int                  seed = 32'h774f;
  oscb_host host (.mclk_i(mclk_i), .ready_i(ready_o), .rvalid_i(rvalid_o),
    .rdata_i(rdata_o), .wr_o(wr_i), .rd_o(rd_i), .addr_o(addr_i),
    .wdata_o(wdata_i));
  oscb_bank dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .wr_i(wr_i),
    .rd_i(rd_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .raw_angle_i(raw_angle_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
    .ready_o(ready_o), .unlocked_o(unlocked_o), .prog_busy_o(prog_busy_o),
    .position_o(position_o), .cfg_o(cfg_o));
  task automatic check(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rchk(string what, logic [4:0] a, logic [7:0] exp);
    host.rd_reg(a, rd_v);
    check(what, {8'h00, exp}, {8'h00, rd_v});
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic reset_dut;
    @(posedge mclk_i);
    #2 sys_rst_i = 1'b1;
    repeat (2) @(posedge mclk_i);
    #2 sys_rst_i = 1'b0;
  endtask
  function automatic logic [4:0] abs_of(logic [1:0] c);
    case (c)
      2'b00: return 5'h10;
      2'b01: return 5'h0e;
      2'b10: return 5'h0c;
      default: return 5'h0a;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  initial forever #12.5 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 3000) begin
      bad_count++;
      close_out();
    end
  end
  initial begin
    reset_dut();
    host.wr_reg(oscb_pkg::ADDR_KEY, oscb_pkg::KEY_UNLOCK);
    for (int a = 7; a < 10; a++) host.wr_reg(a[4:0], 8'h00);
    host.wr_reg(oscb_pkg::ADDR_SUPPLY, 8'h02);
    host.wr_reg(oscb_pkg::ADDR_CMD_HI, oscb_pkg::CMD_PROG_VOLT);
    check("volt busy", 16'h0001, {15'h0, prog_busy_o});
    reset_dut();
    rchk("supply byte", oscb_pkg::ADDR_SUPPLY, 8'h02);
    check("supply", 16'h0001, {15'h0, cfg_o.supply_high});
    $display("supply level test done");
    for (int a = 0; a < 7; a++) rchk("reset value", a[4:0], 8'h00);
    check("locked", 16'h0000, {15'h0, unlocked_o});
    d = 8'($random(seed));
    host.wr_reg(oscb_pkg::ADDR_OUT_CFG, d | 8'h01);
    rchk("locked write", oscb_pkg::ADDR_OUT_CFG, 8'h00);
    host.wr_reg(oscb_pkg::ADDR_USER1, d);
    rchk("user byte", oscb_pkg::ADDR_USER1, d);
    $display("locking test done");
    host.wr_reg(oscb_pkg::ADDR_KEY, oscb_pkg::KEY_UNLOCK);
    rchk("key state", oscb_pkg::ADDR_KEY, 8'h01);
    for (int i = 0; i < 8; i++) begin
      d = 8'($random(seed));
      d[2:0] = i[2:0];
      host.wr_reg(oscb_pkg::ADDR_OUT_CFG, d);
      check("out cfg", {7'h0, d[7:3], {1'b0, d[2:0]} + 4'h1}, {7'h0,
        cfg_o.commutation_or_pulse_select, cfg_o.pwm_period_code,
        cfg_o.index_width_code, cfg_o.pole_pairs});
      inc = 8'($random(seed));
      inc[7:4] = i[3:0];
      host.wr_reg(oscb_pkg::ADDR_INC_CFG, inc);
      check("cpr", {3'h0, 13'h0020 << i}, {3'h0, cfg_o.counts_per_rev});
      check("hyst", {12'h0, inc[3:0]}, {12'h0, cfg_o.hysteresis_code});
      d = 8'($random(seed));
      d[5:4] = i[1:0];
      // low delay only up to 1024 counts
      if (i > 5) d[6] = 1'b0;
      // host picks the matching second field
      d[3:0] = d[6] ? 4'h5 : 4'h4;
      host.wr_reg(oscb_pkg::ADDR_RES_CFG, d);
      check("res cfg", {5'h0, d[7:6], abs_of(d[5:4]), d[3:0]}, {5'h0,
        cfg_o.count_ccw, cfg_o.low_delay, cfg_o.abs_bits,
        cfg_o.cpr2_code});
    end
    rchk("retained", oscb_pkg::ADDR_RES_CFG, d);
    zl = 8'($random(seed));
    zh = 8'($random(seed));
    host.wr_reg(oscb_pkg::ADDR_ZERO_LO, zl);
    host.wr_reg(oscb_pkg::ADDR_ZERO_HI, zh);
    for (int k = 0; k < 4; k++) begin
      raw_angle_i = (k == 0) ? {zh, zl} : 16'($random(seed));
      @(posedge mclk_i);
      #2;
      check("position", raw_angle_i - {zh, zl}, position_o);
    end
    host.wr_reg(oscb_pkg::ADDR_CMD_ZERO, oscb_pkg::CMD_PROG_ZERO);
    $display("decode and offset test done");
    d = 8'($random(seed));
    if (d == oscb_pkg::KEY_UNLOCK) d = 8'h00;
    host.wr_reg(oscb_pkg::ADDR_KEY, d);
    check("relock", 16'h0000, {15'h0, unlocked_o});
    host.wr_reg(oscb_pkg::ADDR_INC_CFG, ~inc);
    rchk("relocked write", oscb_pkg::ADDR_INC_CFG, inc);
    rchk("unmapped", 5'h1f, 8'h00);
    host.wr_reg(oscb_pkg::ADDR_CMD_CAL, oscb_pkg::CMD_PROG_CAL);
    check("cal busy", 16'h0001, {15'h0, prog_busy_o});
    reset_dut();
    rchk("kept low", oscb_pkg::ADDR_ZERO_LO, zl);
    rchk("kept high", oscb_pkg::ADDR_ZERO_HI, zh);
    rchk("no writeback", oscb_pkg::ADDR_OUT_CFG, 8'h00);
    check("locked again", 16'h0000, {15'h0, unlocked_o});
    $display("power cycle test done");
    close_out();
  end
endmodule // testbench
bind oscb_bank oscb_bank_props u_props (.mclk_i(mclk_i),
  .sys_rst_i(sys_rst_i), .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i),
  .wdata_i(wdata_i), .raw_angle_i(raw_angle_i), .rdata_o(rdata_o),
  .rvalid_o(rvalid_o), .ready_o(ready_o), .unlocked_o(unlocked_o),
  .prog_busy_o(prog_busy_o), .position_o(position_o), .cfg_o(cfg_o));
